// ==== rtl/dbgcp_core.sv ====
// Purpose: Debug command processor: decodes host bytes, reaches memories
// Assumes: Host bytes arrive as valid pulses on clk_sys; memory answers in one cycle
// Notes: Survives its own commanded system reset
`timescale 1ns/100ps
`default_nettype none
`include "dbgcp_defs.svh"
module dbgcp_core
   import dbgcp_pkg::*;
#(
   parameter int PM_BYTES = 65536
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [7:0] tx_data,
   input wire logic read_protect,
   input wire logic flash_unlocked,
   input wire logic break_decoded,
   input wire logic [7:0] cpu_opcode,
   input wire logic watch_hit,
   input wire logic sys_reset_done,
   input wire logic instr_done,
   input wire logic [7:0] mem_rdata,
   output logic mem_req,
   output dbgcp_mem_req_t mem_cmd,
   output logic cpu_halt,
   output logic sys_reset_req,
   output logic step_req,
   output logic stuff_req,
   output logic [7:0] stuff_byte,
   output logic [7:0] debugger_control,
   output logic [7:0] watch_control,
   output logic [7:0] watch_address_low,
   output logic [7:0] watch_match_data
);
   typedef enum {
      ST_CMD, ST_A1, ST_A0, ST_S1, ST_S0, ST_WDAT, ST_RDAT, ST_RWAIT,
      ST_CRC, ST_CRC_H, ST_CRC_L, ST_ONE, ST_EXEC, ST_WPT, ST_CTL, ST_RWPT
   } dbgcp_st_t;
   dbgcp_st_t st_r;
   logic [7:0] cmd_r, ctl_r, wctl_r, wadr_r, wdat_r, ob_r, stb_r;
   logic [15:0] addr_r, size_r, crc_r, crc_nxt;
   logic [16:0] left_r;
   logic [1:0] idx_r;
   logic [2:0] exec_left_r;
   logic mreq_r, mwr_r, ovld_r, step_r, stuff_r, exec_r, rstq_r, brk_r;
   wire halted = ctl_r[`DBGCP_CTL_HALT];
   wire blocked = !halted || read_protect;
   wire ob_ready;
   // ----------------------------------------
   // Decoding
   // ----------------------------------------
   function automatic logic is_addr_cmd(input logic [7:0] c);
      return c == `DBGCP_CMD_RD_REG || c == `DBGCP_CMD_WR_PM || c == `DBGCP_CMD_RD_PM ||
             c == `DBGCP_CMD_WR_DM || c == `DBGCP_CMD_RD_DM;
   endfunction
   wire is_wr = (cmd_r == `DBGCP_CMD_WR_PM) || (cmd_r == `DBGCP_CMD_WR_DM);
   // Write permitted only when halted, unprotected, and flash open for program space
   wire wr_ok = !blocked && (cmd_r != `DBGCP_CMD_WR_PM || flash_unlocked);
   // Fill choice: data memory ignores read protection
   wire rd_fill = (cmd_r == `DBGCP_CMD_RD_DM) ? !halted : blocked;
   wire [1:0] space = (cmd_r == `DBGCP_CMD_RD_REG) ? 2'(DBGCP_SP_REG) :
                      (cmd_r == `DBGCP_CMD_WR_PM || cmd_r == `DBGCP_CMD_RD_PM ||
                       cmd_r == `DBGCP_CMD_CRC) ? 2'(DBGCP_SP_PM) : 2'(DBGCP_SP_DM);
   // Instruction length from opcode low and high nibbles; a small stand-in table
   wire [2:0] op_len = (rx_data[3:0] >= 4'h8) ? 3'd1 : (rx_data[7:4] == 4'h0) ? 3'd1 : 3'd2;
   wire brk_evt = (break_decoded && cpu_opcode == `DBGCP_BREAK_OPCODE &&
                   ctl_r[`DBGCP_CTL_BREAKPOINT_ENABLE]) || watch_hit;
   // Watch control write value, cleared when blocked
   wire [7:0] wctl_in = blocked ? 8'h00 : rx_data;
   // Control write: halt cannot be cleared under protection
   wire [7:0] ctl_wr = {rx_data[7] | (read_protect & halted), rx_data[6:0]}
                       & `DBGCP_CTL_MASK;
   dbgcp_crc u_crc (
      .crc_in(crc_r),
      .data(mem_rdata),
      .crc_out(crc_nxt)
   );
   dbgcp_skid #(.WIDTH(8), .DEPTH(2)) u_skid (
      .clk_sys(clk_sys),
      .reset(reset),
      .in_valid(ovld_r),
      .in_ready(ob_ready),
      .in_data(ob_r),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(tx_data)
   );
   // Reply byte in flight is taken when buffer has room
   wire o_free = !ovld_r || ob_ready;
   // ----------------------------------------
   // Command state machine
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_r <= ST_CMD;
         cmd_r <= 8'h00;
         ctl_r <= `DBGCP_CTL_RESET;
         wctl_r <= 8'h00;
         wadr_r <= 8'h00;
         wdat_r <= 8'h00;
         addr_r <= 16'h0000;
         size_r <= 16'h0000;
         left_r <= 17'h0_0000;
         crc_r <= `DBGCP_CRC_SEED;
         idx_r <= 2'd0;
         exec_left_r <= 3'd0;
         mreq_r <= 1'b0;
         mwr_r <= 1'b0;
         ovld_r <= 1'b0;
         ob_r <= 8'h00;
         step_r <= 1'b0;
         stuff_r <= 1'b0;
         stb_r <= 8'h00;
         exec_r <= 1'b0;
         rstq_r <= 1'b0;
         brk_r <= 1'b0;
      end else begin
         mreq_r <= 1'b0;
         step_r <= 1'b0;
         stuff_r <= 1'b0;
         if (ovld_r && ob_ready) ovld_r <= 1'b0;
         // Self-reset clears when the system reset finishes
         if (sys_reset_done) ctl_r[`DBGCP_CTL_RST] <= 1'b0;
         rstq_r <= ctl_r[`DBGCP_CTL_RST] && !sys_reset_done;
         // Write address steps only after its request has been shown
         if (mreq_r && mwr_r) addr_r <= addr_r + 16'h0001;
         case (st_r)
            ST_CMD: begin
               if (brk_r && o_free && !rx_valid) begin
                  ob_r <= `DBGCP_ACK_BYTE;
                  ovld_r <= 1'b1;
                  brk_r <= 1'b0;
               end else if (rx_valid) begin
                  cmd_r <= rx_data;
                  idx_r <= 2'd0;
                  if (is_addr_cmd(rx_data)) st_r <= ST_A1;
                  else if (rx_data == `DBGCP_CMD_WR_CTL) st_r <= ST_CTL;
                  else if (rx_data == `DBGCP_CMD_RD_CTL) begin
                     ob_r <= ctl_r;
                     ovld_r <= 1'b1;
                     st_r <= ST_RWAIT;
                  end else if (rx_data == `DBGCP_CMD_CRC) begin
                     addr_r <= 16'h0000;
                     left_r <= 17'(PM_BYTES);
                     crc_r <= `DBGCP_CRC_SEED;
                     st_r <= halted ? ST_CRC : ST_CRC_H;
                     if (!halted) crc_r <= `DBGCP_FILL_CRC;
                  end else if (rx_data == `DBGCP_CMD_STEP) begin
                     step_r <= !blocked;
                  end else if (rx_data == `DBGCP_CMD_STUFF || rx_data == `DBGCP_CMD_EXEC) begin
                     st_r <= ST_ONE;
                  end else if (rx_data == `DBGCP_CMD_WR_WPT) st_r <= ST_WPT;
                  else if (rx_data == `DBGCP_CMD_RD_WPT) st_r <= ST_RWPT;
                  // Other codes fall through; the next byte is a command
               end
            end
            ST_A1: if (rx_valid) begin
               addr_r[15:8] <= (cmd_r == `DBGCP_CMD_RD_REG) ? {4'h0, rx_data[3:0]} : rx_data;
               st_r <= ST_A0;
            end
            ST_A0: if (rx_valid) begin
               addr_r[7:0] <= rx_data;
               st_r <= (cmd_r == `DBGCP_CMD_RD_REG) ? ST_S0 : ST_S1;
            end
            ST_S1: if (rx_valid) begin
               size_r[15:8] <= rx_data;
               st_r <= ST_S0;
            end
            ST_S0: if (rx_valid) begin
               // Zero size selects the full range
               if (cmd_r == `DBGCP_CMD_RD_REG)
                  left_r <= (rx_data == 8'h00) ? 17'd256 : {9'h000, rx_data};
               else if ({size_r[15:8], rx_data} == 16'h0000)
                  left_r <= 17'h1_0000;
               else
                  left_r <= {1'b0, size_r[15:8], rx_data};
               st_r <= is_wr ? ST_WDAT : ST_RDAT;
            end
            ST_WDAT: if (rx_valid) begin
               mreq_r <= wr_ok;
               mwr_r <= 1'b1;
               ob_r <= rx_data;
               left_r <= left_r - 17'd1;
               if (left_r == 17'd1) st_r <= ST_CMD;
            end
            ST_RDAT: if (o_free && !mreq_r) begin
               mreq_r <= !rd_fill;
               mwr_r <= 1'b0;
               st_r <= ST_RWAIT;
            end
            ST_RWAIT: begin
               // Memory data lands one cycle after the request
               if (cmd_r == `DBGCP_CMD_RD_CTL) st_r <= ST_CMD;
               else begin
                  ob_r <= rd_fill ? `DBGCP_FILL_BYTE : mem_rdata;
                  ovld_r <= 1'b1;
                  addr_r <= addr_r + 16'h0001;
                  left_r <= left_r - 17'd1;
                  st_r <= (left_r == 17'd1) ? ST_CMD : ST_RDAT;
               end
            end
            ST_CRC: begin
               // One memory byte per two cycles walk
               if (!mreq_r) begin
                  mreq_r <= 1'b1;
                  mwr_r <= 1'b0;
               end else begin
                  crc_r <= crc_nxt;
                  addr_r <= addr_r + 16'h0001;
                  left_r <= left_r - 17'd1;
                  if (left_r == 17'd1) st_r <= ST_CRC_H;
               end
            end
            ST_CRC_H: if (o_free) begin
               ob_r <= crc_r[15:8];
               ovld_r <= 1'b1;
               st_r <= ST_CRC_L;
            end
            ST_CRC_L: if (o_free) begin
               ob_r <= crc_r[7:0];
               ovld_r <= 1'b1;
               st_r <= ST_CMD;
            end
            ST_ONE: if (rx_valid) begin
               if (cmd_r == `DBGCP_CMD_STUFF || blocked) begin
                  // Stuff takes one opcode; blocked execute eats one byte
                  stuff_r <= !blocked;
                  stb_r <= rx_data;
                  st_r <= ST_CMD;
               end else begin
                  stuff_r <= 1'b1;
                  stb_r <= rx_data;
                  exec_left_r <= op_len - 3'd1;
                  st_r <= (op_len == 3'd1) ? ST_CMD : ST_EXEC;
               end
            end
            ST_EXEC: if (rx_valid) begin
               mreq_r <= 1'b1;
               mwr_r <= 1'b1;
               ob_r <= rx_data;
               exec_left_r <= exec_left_r - 3'd1;
               if (exec_left_r == 3'd1) st_r <= ST_CMD;
            end
            ST_CTL: if (rx_valid) begin
               ctl_r <= ctl_wr;
               st_r <= ST_CMD;
            end
            ST_WPT: if (rx_valid) begin
               // Control, address low, then match data
               if (idx_r == 2'd0) wctl_r <= wctl_in;
               if (idx_r == 2'd1) wadr_r <= rx_data;
               if (idx_r == 2'd2) wdat_r <= rx_data;
               idx_r <= idx_r + 2'd1;
               if (idx_r == 2'd2) st_r <= ST_CMD;
            end
            ST_RWPT: if (o_free) begin
               ob_r <= (idx_r == 2'd0) ? wctl_r : (idx_r == 2'd1) ? wadr_r : wdat_r;
               ovld_r <= 1'b1;
               idx_r <= idx_r + 2'd1;
               if (idx_r == 2'd2) st_r <= ST_CMD;
            end
            default: st_r <= ST_CMD;
         endcase
         // Break comes last so that, while running, it wins over a host write in the same cycle
         if (brk_evt && !halted) begin
            ctl_r[`DBGCP_CTL_HALT] <= 1'b1;
            if (ctl_r[`DBGCP_CTL_ACKEN]) brk_r <= 1'b1;
         end
      end
   end
   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign mem_req = mreq_r;
   assign mem_cmd = '{space: space, write: mwr_r, addr: addr_r, wdata: ob_r};
   assign cpu_halt = ctl_r[`DBGCP_CTL_HALT];
   assign sys_reset_req = rstq_r;
   assign step_req = step_r;
   assign stuff_req = stuff_r;
   assign stuff_byte = stb_r;
   assign debugger_control = ctl_r;
   assign watch_control = wctl_r;
   assign watch_address_low = wadr_r;
   assign watch_match_data = wdat_r;
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   protect_halt_a: assert property (@(posedge clk_sys) disable iff (reset)
      (read_protect && halted) |=> halted) else $error("halt cleared under protection");
   wpt_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
      (st_r == ST_WPT && idx_r == 2'd0 && rx_valid && blocked) |=> wctl_r == 8'h00)
      else $error("watch control not forced zero");
   step_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
      step_r |-> $past(halted) && !$past(read_protect)) else $error("step while blocked");
   write_drop_a: assert property (@(posedge clk_sys) disable iff (reset)
      (mreq_r && mwr_r && st_r != ST_EXEC) |-> !$past(blocked))
      else $error("memory write while blocked");
   flash_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
      (mreq_r && mwr_r && cmd_r == `DBGCP_CMD_WR_PM) |-> $past(flash_unlocked))
      else $error("program write while flash locked");
   brk_halt_a: assert property (@(posedge clk_sys) disable iff (reset)
      (brk_evt && st_r != ST_CTL) |=> halted) else $error("break did not halt");
   crc_fill_a: assert property (@(posedge clk_sys) disable iff (reset)
      (st_r == ST_CMD && rx_valid && rx_data == `DBGCP_CMD_CRC && !halted)
      |=> crc_r == `DBGCP_FILL_CRC) else $error("crc fill missing");
   regsize_a: assert property (@(posedge clk_sys) disable iff (reset)
      (st_r == ST_S0 && rx_valid && cmd_r == `DBGCP_CMD_RD_REG && rx_data == 8'h00)
      |=> left_r == 17'd256) else $error("register size zero not 256");
   rst_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
      (sys_reset_done && st_r != ST_CTL) |=> !ctl_r[`DBGCP_CTL_RST])
      else $error("self reset did not clear");
endmodule
`default_nettype wire

// ==== common/dbgcp_defs.svh ====
// Purpose: Constants of the debug command processor
// Assumes: Included by bare name from the rtl files
// Notes: Definitions only
`ifndef DBGCP_DEFS_SVH
`define DBGCP_DEFS_SVH
// ----------------------------------------
// Command codes
// ----------------------------------------
`define DBGCP_CMD_WR_CTL 8'h04
`define DBGCP_CMD_RD_CTL 8'h05
`define DBGCP_CMD_RD_REG 8'h09
`define DBGCP_CMD_WR_PM 8'h0A
`define DBGCP_CMD_RD_PM 8'h0B
`define DBGCP_CMD_WR_DM 8'h0C
`define DBGCP_CMD_RD_DM 8'h0D
`define DBGCP_CMD_CRC 8'h0E
`define DBGCP_CMD_STEP 8'h10
`define DBGCP_CMD_STUFF 8'h11
`define DBGCP_CMD_EXEC 8'h12
`define DBGCP_CMD_WR_WPT 8'h20
`define DBGCP_CMD_RD_WPT 8'h21
// ----------------------------------------
// Debugger control fields and values
// ----------------------------------------
`define DBGCP_CTL_HALT 7
`define DBGCP_CTL_BREAKPOINT_ENABLE 6
`define DBGCP_CTL_ACKEN 5
`define DBGCP_CTL_RST 0
`define DBGCP_CTL_RESET 8'h00
`define DBGCP_CTL_MASK 8'hE1
`define DBGCP_FILL_BYTE 8'hFF
`define DBGCP_ACK_BYTE 8'hFF
`define DBGCP_FILL_CRC 16'hFFFF
`define DBGCP_CRC_SEED 16'hFFFF
`define DBGCP_CRC_POLY 16'h1021
`define DBGCP_BREAK_OPCODE 8'h00
`endif

// ==== common/dbgcp_pkg.sv ====
// Purpose: Types of the debug command processor
// Assumes: dbgcp_defs.svh holds the numbers
// Notes: Memory requests travel as a packed struct
package dbgcp_pkg;
   // Byte of a stream, data only
   typedef struct packed {
      logic [7:0] data;
   } dbgcp_byte_t;
   // Memory access request toward the system
   typedef struct packed {
      logic [1:0] space;
      logic write;
      logic [15:0] addr;
      logic [7:0] wdata;
   } dbgcp_mem_req_t;
   typedef enum logic [1:0] {
      DBGCP_SP_REG,
      DBGCP_SP_PM,
      DBGCP_SP_DM
   } dbgcp_space_t;
endpackage

// ==== rtl/dbgcp_skid.sv ====
// Purpose: Two-entry buffer on the reply byte path
// Assumes: Both sides on clk_sys
// Notes: Receiver stall loses no byte
`timescale 1ns/100ps
`default_nettype none
module dbgcp_skid
   import dbgcp_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [$clog2(DEPTH):0] cnt_r;
   logic [$clog2(DEPTH)-1:0] wp_r, rp_r;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   // ----------------------------------------
   // Flags
   // ----------------------------------------
   assign in_ready = (cnt_r != ($clog2(DEPTH)+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem_r[rp_r];
   // Pointer and count update
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cnt_r <= '0;
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (push) wp_r <= wp_r + 1'b1;
         if (pop) rp_r <= rp_r + 1'b1;
         cnt_r <= cnt_r + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
      end
   end
   // Storage
   always_ff @(posedge clk_sys) begin
      if (push) mem_r[wp_r] <= in_data;
   end
endmodule
`default_nettype wire

// ==== rtl/dbgcp_crc.sv ====
// Purpose: CRC-CCITT byte update
// Assumes: MSB-first, polynomial 1021
// Notes: Pure combinational step
`timescale 1ns/100ps
`default_nettype none
`include "dbgcp_defs.svh"
module dbgcp_crc (
   input wire logic [15:0] crc_in,
   input wire logic [7:0] data,
   output logic [15:0] crc_out
);
   // One shift per data bit, unrolled by the loop
   always_comb begin
      logic [15:0] c;
      c = crc_in;
      for (int i = 7; i >= 0; i--) begin
         if (c[15] ^ data[i]) c = {c[14:0], 1'b0} ^ `DBGCP_CRC_POLY;
         else c = {c[14:0], 1'b0};
      end
      crc_out = c;
   end
endmodule
`default_nettype wire

// ==== tb/dbgcp_host.sv ====
// Purpose: Debug host model sending command bytes and taking replies
// Assumes: Replies are taken under valid and ready on clk_sys
// Notes: stall holds off each reply to exercise the reply buffer
`timescale 1ns/100ps
`default_nettype none
module dbgcp_host (
   input wire logic clk_sys,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic tx_ready
);
   // ----------------------------------------
   // Byte tasks
   // ----------------------------------------
   int stall = 0;
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      tx_ready = 1'b0;
   end
   // One byte per pulse; idle data is inverted so a stale byte is never reused
   task automatic put(input logic [7:0] b);
      @(posedge clk_sys);
      rx_valid <= 1'b1;
      rx_data <= b;
      @(posedge clk_sys);
      rx_valid <= 1'b0;
      rx_data <= ~b;
   endtask
   // Bounded wait long enough for the whole-memory CRC walk
   task automatic get(output logic [7:0] b);
      int n;
      b = 8'hxx;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (tx_valid !== 1'b1 && n < 300);
      if (tx_valid === 1'b1) begin
         repeat (stall) @(posedge clk_sys);
         tx_ready <= 1'b1;
         @(posedge clk_sys);
         b = tx_data;
         tx_ready <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ==== tb/dbgcp_bench.sv ====
// Purpose: Self-checking bench of the debug command processor
// Assumes: Memory answers one cycle after each request
// Notes: Program memory shortened to 16 bytes so the CRC walk is quick
`timescale 1ns/100ps
`default_nettype none
module dbgcp_bench;
   import dbgcp_pkg::*;
   // ----------------------------------------
   // Signals, clock, device and partners
   // ----------------------------------------
   logic clk_sys, reset, read_protect, flash_unlocked, break_decoded, watch_hit, sys_reset_done;
   logic rx_valid, tx_valid, tx_ready, mem_req, cpu_halt, sys_reset_req, step_req, stuff_req;
   logic [7:0] rx_data, tx_data, cpu_opcode, mem_rdata, stuff_byte, debugger_control;
   logic [7:0] watch_control, watch_address_low, watch_match_data, b0, b1, b2;
   logic instr_done;
   logic [15:0] wr_last;
   dbgcp_mem_req_t mem_cmd;
   int n_fail = 0, compares = 0, n_wr = 0, n_step = 0, n_stuff = 0, k;
   always #50 clk_sys = ~clk_sys;
   dbgcp_core #(.PM_BYTES(16)) DUT (.clk_sys(clk_sys), .reset(reset), .rx_valid(rx_valid),
      .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
      .read_protect(read_protect), .flash_unlocked(flash_unlocked),
      .break_decoded(break_decoded), .cpu_opcode(cpu_opcode), .watch_hit(watch_hit),
      .sys_reset_done(sys_reset_done), .instr_done(instr_done), .mem_rdata(mem_rdata),
      .mem_req(mem_req), .mem_cmd(mem_cmd), .cpu_halt(cpu_halt),
      .sys_reset_req(sys_reset_req), .step_req(step_req), .stuff_req(stuff_req),
      .stuff_byte(stuff_byte), .debugger_control(debugger_control),
      .watch_control(watch_control), .watch_address_low(watch_address_low),
      .watch_match_data(watch_match_data));
   dbgcp_host host (.clk_sys(clk_sys), .tx_valid(tx_valid), .tx_data(tx_data),
      .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready));
   // Memory gives low address byte xor A5 so addresses within one 256-byte page are told apart; CPU ends each run
   always @(posedge clk_sys) begin
      mem_rdata <= mem_cmd.addr[7:0] ^ 8'hA5;
      instr_done <= step_req | stuff_req;
      if (mem_req === 1'b1 && mem_cmd.write === 1'b1) begin
         n_wr++;
         wr_last <= {mem_cmd.addr[7:0], mem_cmd.wdata};
      end
      if (step_req === 1'b1) n_step++;
      if (stuff_req === 1'b1) n_stuff++;
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      if (n_fail == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Reference CRC-CCITT, seed FFFF, MSB first, over the bench memory contents
   function automatic logic [15:0] crc_ref(input int n);
      logic [15:0] c;
      logic [7:0] d;
      c = 16'hFFFF;
      for (int a = 0; a < n; a++) begin
         d = 8'(a) ^ 8'hA5;
         for (int i = 7; i >= 0; i--) begin
            c = (c[15] ^ d[i]) ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
         end
      end
      return c;
   endfunction
   task automatic hdr(input logic [7:0] c, input logic [15:0] a, input logic [15:0] s);
      host.put(c);
      host.put(a[15:8]);
      host.put(a[7:0]);
      host.put(s[15:8]);
      host.put(s[7:0]);
   endtask
   task automatic ctl(input logic [7:0] v);
      host.put(8'h04);
      host.put(v);
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic pulse_in(input int which, input logic [7:0] op);
      @(posedge clk_sys);
      cpu_opcode <= op;
      if (which == 0) sys_reset_done <= 1'b1;
      else if (which == 1) break_decoded <= 1'b1;
      else watch_hit <= 1'b1;
      @(posedge clk_sys);
      sys_reset_done <= 1'b0;
      break_decoded <= 1'b0;
      watch_hit <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // Running CPU: every read is filled, step ignored
   task automatic t_running;
      chk({debugger_control, watch_control}, 16'h0000);
      hdr(8'h0D, 16'h0010, 16'h0001);
      host.get(b0);
      chk(b0, 16'h00FF);
      hdr(8'h0B, 16'h0010, 16'h0001);
      host.get(b0);
      chk(b0, 16'h00FF);
      host.put(8'h09); host.put(8'h00); host.put(8'h10); host.put(8'h01);
      host.get(b0);
      chk(b0, 16'h00FF);
      host.put(8'h0E);
      host.get(b0);
      host.get(b1);
      chk({b0, b1}, 16'hFFFF);
      host.put(8'h10);
      repeat (4) @(posedge clk_sys);
      chk(n_step, 0);
   endtask
   // Reset and stop, then halted accesses, the first data read with a slow host
   task automatic t_halted;
      ctl(8'h81);
      chk({cpu_halt, sys_reset_req}, 2'b11);
      pulse_in(0, 8'h00);
      chk({sys_reset_req, debugger_control}, 16'h0080);
      host.stall = 3;
      hdr(8'h0D, 16'hFFFF, 16'h0002);
      host.get(b0);
      host.get(b1);
      chk({b0, b1}, 16'h5AA5);
      host.stall = 0;
      host.put(8'h09); host.put(8'h0F); host.put(8'hFF); host.put(8'h00);
      for (int i = 0; i < 256; i++) begin
         host.get(b0);
         if (i == 0) chk(b0, 16'h005A);
      end
      repeat (8) @(posedge clk_sys);
      chk(tx_valid, 1'b0);
      k = n_wr;
      hdr(8'h0C, 16'h0040, 16'h0001);
      host.put(8'h77);
      hdr(8'h0A, 16'h0040, 16'h0001);
      host.put(8'h77);
      repeat (4) @(posedge clk_sys);
      chk(n_wr - k, 1);
      chk(wr_last, 16'h4077);
      flash_unlocked <= 1'b1;
      hdr(8'h0A, 16'h0040, 16'h0001);
      host.put(8'h78);
      repeat (4) @(posedge clk_sys);
      chk(n_wr - k, 2);
      chk(wr_last, 16'h4078);
      k = n_wr;
      host.put(8'h11);
      host.put(8'h3C);
      repeat (2) @(posedge clk_sys);
      chk(stuff_byte, 16'h003C);
      host.put(8'h12);
      host.put(8'h12);
      host.put(8'hAB);
      repeat (4) @(posedge clk_sys);
      chk({n_stuff[3:0], n_wr[3:0] - k[3:0], wr_last[7:0]}, 16'h21AB);
      host.put(8'h0E);
      host.get(b0);
      host.get(b1);
      chk({b0, b1}, crc_ref(16));
      host.put(8'h10);
      repeat (4) @(posedge clk_sys);
      chk(n_step, 1);
      host.put(8'h20); host.put(8'hA3); host.put(8'h12); host.put(8'h34);
      host.put(8'h21);
      host.get(b0);
      host.get(b1);
      host.get(b2);
      chk({b0, b1}, 16'hA312);
      chk({b2, watch_match_data}, 16'h3434);
   endtask
   // Run with breakpoints and acknowledge on, then break
   task automatic t_break;
      ctl(8'h60);
      chk(cpu_halt, 1'b0);
      pulse_in(1, 8'h01);
      chk(debugger_control, 16'h0060);
      pulse_in(1, 8'h00);
      chk(debugger_control, 16'h00E0);
      host.get(b0);
      chk(b0, 16'h00FF);
      ctl(8'h60);
      pulse_in(2, 8'h00);
      chk(debugger_control, 16'h00E0);
      host.get(b0);
      chk(b0, 16'h00FF);
   endtask
   // Protected: halt sticks, writes and watch control blocked
   task automatic t_protect;
      read_protect <= 1'b1;
      ctl(8'h20);
      chk(debugger_control[7], 1'b1);
      k = n_wr;
      hdr(8'h0C, 16'h0040, 16'h0001);
      host.put(8'h55);
      host.put(8'h10);
      host.put(8'h20); host.put(8'hE1); host.put(8'h12); host.put(8'h34);
      repeat (4) @(posedge clk_sys);
      chk({n_wr[3:0] - k[3:0], n_step[3:0], watch_control}, 16'h0100);
      hdr(8'h0B, 16'h0010, 16'h0001);
      host.get(b0);
      chk(b0, 16'h00FF);
      host.put(8'h30);
      host.put(8'h11);
      host.put(8'h3C);
      host.put(8'h12);
      host.put(8'h12);
      host.put(8'h05);
      host.get(b0);
      chk(b0, 16'h00A0);
      chk(n_stuff, 2);
   endtask
   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      clk_sys = 1'b0;
      reset = 1'b1;
      {read_protect, break_decoded, watch_hit, sys_reset_done} = 4'h0;
      flash_unlocked = 1'b0;
      cpu_opcode = 8'h00;
      mem_rdata = 8'h00;
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      t_running;
      t_halted;
      t_break;
      t_protect;
      complete_run;
   end
   initial begin
      #(100 * 20000);
      n_fail++;
      complete_run;
   end
endmodule
`default_nettype wire
